// ---- core/host_port_pkg.sv ----
// Constants shared by the host parallel port, its host model and its bench
// Function
// [RL1] The four operation address lines pick the operation, line 0 lowest.
// [RL2] With device select high the data bus stays undriven and nothing runs.
// [RL3] A write happens only on write strobe and select low with read high.
// [RL4] A read happens only on read strobe and select low with write high.
// [RL5] The width strap gives 8-bit mode low, 16-bit mode high, bit 0 lowest.
// [RL6] In 8-bit mode the host ties data line n to line n+8 for n 0 to 7.
// [RL7] Master reset low clears all registers and buffers for 0.5 us or more.
package host_port_pkg;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 4;
   localparam int DEPTH = 16;
   localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;
   localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
   localparam logic STRAP_8BIT = 1'b0;
   localparam int CLK_PERIOD_NS = 50;
   localparam int RESET_LOW_NS = 500;
   localparam int RESET_LOW_CYCLES =
      (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_CNT_W = 4;
   localparam logic [RESET_CNT_W-1:0] RESET_CNT_ZERO = 4'h0;
   localparam logic [RESET_CNT_W-1:0] RESET_CNT_DONE =
      RESET_CNT_W'(RESET_LOW_CYCLES);
endpackage

// ---- core/port_reg_store.sv ----
// Small register store behind the host port, with registered read data
`timescale 1ns/10ps
module port_reg_store #(
   parameter int DATA_W = 16,
   parameter int ADDR_W = 4,
   parameter int DEPTH = 16
) (
   // Clock and clear
   input wire logic clk,
   input wire logic clear,
   // Host write port
   input wire logic we,
   input wire logic [ADDR_W-1:0] waddr,
   input wire logic [DATA_W-1:0] wdata,
   // Host read port
   input wire logic [ADDR_W-1:0] raddr,
   output logic [DATA_W-1:0] rdata,
   // Core read port
   input wire logic [ADDR_W-1:0] core_addr,
   output logic [DATA_W-1:0] core_data
);
   logic [DATA_W-1:0] mem [DEPTH];

   // Flop array rather than RAM so one clear empties every word
   always_ff @(posedge clk) begin
      if (clear) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
      end else if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (clear) begin
         rdata <= '0;
         core_data <= '0;
      end else begin
         rdata <= mem[raddr];
         core_data <= mem[core_addr];
      end
   end
endmodule

// ---- core/host_parallel_port.sv ----
// Host parallel port: strobe decode, byte pairing and reset handling
`timescale 1ns/10ps
module host_parallel_port
   import host_port_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic master_reset_n,
   // Host strobes and address
   input wire logic [host_port_pkg::ADDR_W-1:0] op_address,
   input wire logic device_select_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic bus_width_strap,
   // Host data bus, split
   input wire logic [host_port_pkg::DATA_W-1:0] host_data_in,
   output logic [host_port_pkg::DATA_W-1:0] host_data_out,
   output logic host_data_oe,
   // Core side
   output logic write_op,
   output logic [host_port_pkg::ADDR_W-1:0] write_op_code,
   output logic [host_port_pkg::DATA_W-1:0] write_word,
   output logic read_op,
   output logic [host_port_pkg::ADDR_W-1:0] read_op_code,
   input wire logic [host_port_pkg::ADDR_W-1:0] core_addr,
   output logic [host_port_pkg::DATA_W-1:0] core_data,
   output logic reset_too_short
);
   import host_port_pkg::*;

   logic clear;
   logic wide;
   logic wr_act, rd_act, wr_prev, rd_prev, wr_start, rd_start;
   logic byte_hi;
   logic [BYTE_W-1:0] low_hold;
   logic [BYTE_W-1:0] hi_hold;
   logic rd_pending;
   logic rd_second;
   logic mem_we;
   logic [DATA_W-1:0] next_word;
   logic [DATA_W-1:0] mem_rdata;
   logic [RESET_CNT_W-1:0] reset_cnt;

   // Replicate a byte onto both halves, matching the host's tied lines
   function automatic logic [DATA_W-1:0] both_halves(
      input logic [BYTE_W-1:0] b);
      both_halves = {b, b};
   endfunction

   assign clear = srst | ~master_reset_n; // see [RL7]
   assign wide = (bus_width_strap != STRAP_8BIT); // see [RL5]
   // Select gates both strobes, and the other strobe must stay high
   assign wr_act = ~device_select_n & ~write_strobe_n & read_strobe_n; // see [RL3]
   assign rd_act = ~device_select_n & ~read_strobe_n & write_strobe_n; // see [RL4]
   assign wr_start = wr_act & ~wr_prev & ~clear;
   assign rd_start = rd_act & ~rd_prev & ~clear;
   // One operation per strobe, taken on its leading edge
   always_ff @(posedge clk) begin
      if (clear) begin
         wr_prev <= 1'b0;
         rd_prev <= 1'b0;
      end else begin
         wr_prev <= wr_act;
         rd_prev <= rd_act;
      end
   end

   // Byte order is low then high; a switch to 16-bit mode mid-pair restarts the pair
   always_ff @(posedge clk) begin
      if (clear) begin
         byte_hi <= 1'b0;
      end else if (!wide && (wr_start || rd_start)) begin
         byte_hi <= ~byte_hi; // see [RL5]
      end else if (wide) begin
         byte_hi <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (clear) begin
         low_hold <= BYTE_RESET;
      end else if (wr_start && !wide && !byte_hi) begin
         low_hold <= host_data_in[BYTE_W-1:0];
      end
   end

   assign mem_we = wr_start & (wide | byte_hi); // see [RL3]
   always_comb begin
      if (wide) begin
         next_word = host_data_in; // see [RL5]
      end else begin
         next_word = {host_data_in[BYTE_W-1:0], low_hold};
      end
   end

   always_ff @(posedge clk) begin
      if (clear) begin
         write_op <= 1'b0;
         write_op_code <= '0;
         write_word <= WORD_RESET;
      end else begin
         write_op <= mem_we;
         if (mem_we) begin
            write_op_code <= op_address; // see [RL1]
            write_word <= next_word;
         end
      end
   end

   port_reg_store #(
      .DATA_W(DATA_W),
      .ADDR_W(ADDR_W),
      .DEPTH(DEPTH)
   ) store (
      .clk(clk),
      .clear(clear),
      .we(mem_we),
      .waddr(op_address),
      .wdata(next_word),
      .raddr(op_address),
      .rdata(mem_rdata),
      .core_addr(core_addr),
      .core_data(core_data)
   );

   always_ff @(posedge clk) begin
      if (clear) begin
         rd_pending <= 1'b0;
         rd_second <= 1'b0;
         read_op <= 1'b0;
         read_op_code <= '0;
      end else begin
         rd_pending <= rd_start;
         read_op <= rd_start;
         if (rd_start) begin
            rd_second <= ~wide & byte_hi;
            read_op_code <= op_address; // see [RL1]
         end
      end
   end

   // Read word is two clocks behind the strobe edge
   always_ff @(posedge clk) begin
      if (clear) begin
         host_data_out <= WORD_RESET;
         hi_hold <= BYTE_RESET;
      end else if (rd_pending) begin
         if (wide) begin
            host_data_out <= mem_rdata; // see [RL4]
         end else if (!rd_second) begin
            host_data_out <= both_halves(mem_rdata[BYTE_W-1:0]);
            hi_hold <= mem_rdata[DATA_W-1:BYTE_W];
         end else begin
            host_data_out <= both_halves(hi_hold);
         end
      end
   end

   assign host_data_oe = rd_act & ~clear; // see [RL2]

   // Flags a master reset released before the minimum low time
   always_ff @(posedge clk) begin
      if (srst) begin
         reset_cnt <= RESET_CNT_ZERO;
         reset_too_short <= 1'b0;
      end else if (!master_reset_n) begin
         if (reset_cnt != RESET_CNT_DONE) begin
            reset_cnt <= reset_cnt + 1'b1;
         end
         reset_too_short <= 1'b0;
      end else begin
         reset_too_short <= (reset_cnt != RESET_CNT_ZERO) &&
            (reset_cnt != RESET_CNT_DONE); // see [RL7]
         reset_cnt <= RESET_CNT_ZERO;
      end
   end

   idle_no_drive_a: assert property (@(posedge clk) disable iff (srst) // see [RL2]
      device_select_n |-> !host_data_oe && !mem_we && !rd_start)
      else $error("port active while deselected");

   write_needs_strobe_a: assert property (@(posedge clk) disable iff (srst) // see [RL3]
      write_op |-> $past(!device_select_n && !write_strobe_n && read_strobe_n))
      else $error("write without proper strobes");

   wide_write_data_a: assert property (@(posedge clk) disable iff (srst) // see [RL3]
      (wide && wr_start) |=> write_op && write_word == $past(host_data_in))
      else $error("wide write lost or wrong");

   op_code_a: assert property (@(posedge clk) disable iff (srst) // see [RL1]
      write_op |-> write_op_code == $past(op_address))
      else $error("write code not from address");

   read_drive_a: assert property (@(posedge clk) disable iff (srst) // see [RL4]
      host_data_oe |-> !device_select_n && !read_strobe_n && write_strobe_n)
      else $error("bus driven outside a read");

   wide_read_data_a: assert property (@(posedge clk) disable iff (srst) // see [RL4]
      (rd_pending && wide && master_reset_n) |=>
         host_data_out == $past(mem_rdata))
      else $error("read word not presented");

   byte_pair_a: assert property (@(posedge clk) disable iff (srst) // see [RL5]
      (wr_start && !wide && byte_hi) |=>
         write_op && write_word[7:0] == $past(low_hold) &&
         write_word[15:8] == $past(host_data_in[7:0]))
      else $error("byte pair misassembled");

   narrow_first_a: assert property (@(posedge clk) disable iff (srst) // see [RL5]
      (wr_start && !wide && !byte_hi) |=> !write_op && byte_hi)
      else $error("first byte committed early");

   reset_clear_a: assert property (@(posedge clk) disable iff (srst) // see [RL7]
      !master_reset_n |=> !byte_hi && !write_op && !read_op &&
         host_data_out == 16'h0000)
      else $error("master reset did not clear");
endmodule

// ---- verification/host_model.sv ----
// Host processor model running strobe cycles on the parallel port
`timescale 1ns/10ps
module host_model
   import host_port_pkg::*;
(
   // Clock and mode
   input wire logic clk,
   input wire logic bus_width_strap,
   // Strobes and address
   output logic master_reset_n,
   output logic [host_port_pkg::ADDR_W-1:0] op_address,
   output logic device_select_n,
   output logic read_strobe_n,
   output logic write_strobe_n,
   // Data bus wire
   output logic [host_port_pkg::DATA_W-1:0] host_data_in,
   input wire logic [host_port_pkg::DATA_W-1:0] host_data_out,
   input wire logic host_data_oe
);
   logic [DATA_W-1:0] drv = 16'h0000;
   logic drv_en = 1'b0;
   logic [DATA_W-1:0] q;
   // Released bus shows the inverse, never a stale copy
   assign host_data_in = host_data_oe ? host_data_out : (drv_en ? drv : ~drv);
   initial begin
      master_reset_n = 1'b1;
      op_address = 4'h0;
      device_select_n = 1'b1;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
   end
   task automatic cycle(input logic s, r, w, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d, input int hold);
      @(negedge clk);
      op_address = a;
      drv = (bus_width_strap == STRAP_8BIT) ? {d[7:0], d[7:0]} : d;
      drv_en = w & ~r;
      device_select_n = ~s;
      read_strobe_n = ~r;
      write_strobe_n = ~w;
      repeat (hold) @(negedge clk);
      q = host_data_in;
      device_select_n = 1'b1;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
      drv_en = 1'b0;
      // Address hold is over, so scramble it
      op_address = ~a;
   endtask
   task automatic pulse_reset(input int n);
      @(negedge clk);
      master_reset_n = 1'b0;
      repeat (n) @(negedge clk);
      master_reset_n = 1'b1;
   endtask
endmodule

// ---- verification/host_parallel_port_tb.sv ----
// Self-checking bench for the host parallel port
`timescale 1ns/10ps
module host_parallel_port_tb;
   import host_port_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic bus_width_strap = 1'b1;
   logic [ADDR_W-1:0] core_addr = 4'h0;
   logic master_reset_n, device_select_n, read_strobe_n, write_strobe_n;
   logic host_data_oe, write_op, read_op, reset_too_short;
   logic [ADDR_W-1:0] op_address, write_op_code, read_op_code;
   logic [DATA_W-1:0] host_data_in, host_data_out, write_word, core_data;
   int bad_count = 0;
   int total_checks = 0;
   int nw = 0;
   int nr = 0;
   logic oe_seen = 1'b0;
   logic short_seen = 1'b0;
   always #25 clk = ~clk;
   host_model host (.clk, .bus_width_strap, .master_reset_n, .op_address,
      .device_select_n, .read_strobe_n, .write_strobe_n, .host_data_in,
      .host_data_out, .host_data_oe);
   host_parallel_port dut (.clk, .srst, .master_reset_n, .op_address,
      .device_select_n, .read_strobe_n, .write_strobe_n, .bus_width_strap,
      .host_data_in, .host_data_out, .host_data_oe, .write_op,
      .write_op_code, .write_word, .read_op, .read_op_code, .core_addr,
      .core_data, .reset_too_short);
   always @(posedge clk) begin
      if (write_op === 1'b1) nw++;
      if (read_op === 1'b1) nr++;
      if (host_data_oe === 1'b1) oe_seen = 1'b1;
      if (reset_too_short === 1'b1) short_seen = 1'b1;
   end
   task automatic check(input string what, input logic [DATA_W-1:0] s, e);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic t_word16;
      check("idle oe", DATA_W'(host_data_oe), 16'h0000);
      host.cycle(1'b1, 1'b0, 1'b1, 4'h5, 16'ha5c3, 2);
      check("write code", DATA_W'(write_op_code), 16'h0005);
      check("write word", write_word, 16'ha5c3);
      host.cycle(1'b1, 1'b0, 1'b1, 4'ha, 16'h1234, 2);
      check("writes", DATA_W'(nw), 16'h0002);
      host.cycle(1'b1, 1'b1, 1'b0, 4'h5, 16'h0000, 3);
      check("read word", host.q, 16'ha5c3);
      check("read code", DATA_W'(read_op_code), 16'h0005);
      core_addr = 4'ha;
      repeat (2) @(negedge clk);
      check("core word", core_data, 16'h1234);
   endtask
   task automatic t_refused;
      oe_seen = 1'b0;
      host.cycle(1'b0, 1'b1, 1'b1, 4'h5, 16'hffff, 3);
      host.cycle(1'b1, 1'b1, 1'b1, 4'h5, 16'hffff, 3);
      check("refused ops", DATA_W'(nw + nr), 16'h0003);
      check("bus driven", DATA_W'(oe_seen), 16'h0000);
      check("word kept", write_word, 16'h1234);
   endtask
   task automatic t_byte8;
      bus_width_strap = STRAP_8BIT;
      host.cycle(1'b1, 1'b0, 1'b1, 4'h2, 16'h00b7, 2);
      host.cycle(1'b1, 1'b0, 1'b1, 4'h3, 16'h004e, 2);
      check("paired code", DATA_W'(write_op_code), 16'h0003);
      check("paired word", write_word, 16'h4eb7);
      host.cycle(1'b1, 1'b1, 1'b0, 4'h3, 16'h0000, 3);
      check("low byte", host.q, 16'hb7b7);
      host.cycle(1'b1, 1'b1, 1'b0, 4'h9, 16'h0000, 3);
      check("high byte", host.q, 16'h4e4e);
      bus_width_strap = 1'b1;
   endtask
   task automatic t_mreset;
      short_seen = 1'b0;
      host.pulse_reset(RESET_LOW_CYCLES);
      repeat (3) @(negedge clk);
      check("short at limit", DATA_W'(short_seen), 16'h0000);
      check("word cleared", write_word, WORD_RESET);
      core_addr = 4'h5;
      repeat (2) @(negedge clk);
      check("store cleared", core_data, WORD_RESET);
      host.pulse_reset(RESET_LOW_CYCLES - 1);
      repeat (3) @(negedge clk);
      check("short flag", DATA_W'(short_seen), 16'h0001);
   endtask
   initial begin
      #(100000 * 50);
      bad_count++;
      tally_and_finish;
   end
   initial begin
      repeat (16) @(negedge clk);
      srst = 1'b0;
      @(negedge clk);
      t_word16;
      t_refused;
      t_byte8;
      t_mreset;
      tally_and_finish;
   end
endmodule
